/* logic/sdc_pkg.sv */
// constants, register map and types of the sinc decimator with calibration
// Summary of operation
// [R1] start-up conversions come from a sinc1 path
// [R2] after two conversions switch to sinc3 permanently
// [R3] ratios 128..1024: sinc3 decimates by full ratio
// [R4] ratios 2048+: sinc3 at 1024, sinc1 does rest
// [R5] sinc3 response is cubed N-tap box average
// [R6] notches at data-rate multiples, scale with modulator
// [R7] channel restart on enable, input change, resync
// [R8] unsettled results are delivered like settled ones
// [R9] host discards results until settling time passes
// [R10] settling time per ratio from fixed table
// [R11] subtract signed 24-bit offset before output
// [R12] each channel owns high/low offset registers
// [R13] multiply by unsigned 24-bit gain, 800000h unity
// [R14] each channel owns high/low gain registers
// [R15] correction always on; offset 0, gain unity
// [R16] host rewrites coefficients after every reset
// [R17] three-bit field selects one of eight ratios
// [R18] modulator rate is half the main clock
// [R19] wait 256+44 modulator periods after reset
// [R20] offset first, then gain, then saturate
// [R21] both channel words appear with one strobe
package sdc_pkg;
  localparam int SDC_NCH = 2;
  localparam int SDC_DW = 24;
  localparam int SDC_ADR_W = 8;
  localparam int SDC_CIC_W = 32;
  localparam int SDC_CNT_W = 14;
  localparam int SDC_SET_W = 16;
  localparam int SDC_IN_CFG_W = 8;

  // register byte addresses
  localparam logic [7:0] SDC_REG_CLK_CFG = 8'h00;
  localparam logic [7:0] SDC_REG_CHAN_CTRL = 8'h04;
  localparam logic [7:0] SDC_REG_IN_CFG0 = 8'h08;
  localparam logic [7:0] SDC_REG_IN_CFG1 = 8'h0c;
  localparam logic [7:0] SDC_REG_STATUS = 8'h10;
  localparam logic [7:0] SDC_REG_DATA0 = 8'h14;
  localparam logic [7:0] SDC_REG_DATA1 = 8'h18;
  // calibration pages: adr[7:4] picks channel, adr[3:2] the word
  localparam logic [3:0] SDC_CAL_PAGE0 = 4'h2;
  localparam logic [1:0] SDC_CAL_OFF_HI = 2'h0;
  localparam logic [1:0] SDC_CAL_OFF_LO = 2'h1;
  localparam logic [1:0] SDC_CAL_GAIN_HI = 2'h2;
  localparam logic [1:0] SDC_CAL_GAIN_LO = 2'h3;

  // fields
  localparam int SDC_RESYNC_BIT = 8;
  localparam int SDC_COEF_HI_LSB = 8;
  localparam int SDC_ST_FAST_BIT = 2;
  localparam int SDC_ST_RUN_BIT = 3;

  // reset values
  localparam logic [2:0] SDC_OSR_RST = 3'h3;
  localparam logic [1:0] SDC_EN_RST = 2'h3;
  localparam logic [7:0] SDC_IN_CFG_RST = 8'h00;
  localparam logic [23:0] SDC_OFFSET_RST = 24'h000000;
  localparam logic [23:0] SDC_GAIN_RST = 24'h800000;

  // arithmetic
  localparam int SDC_GAIN_FRAC = 23;
  localparam logic [23:0] SDC_POS_MAX = 24'h7fffff;
  localparam logic [23:0] SDC_NEG_MAX = 24'h800000;
  localparam logic [3:0] SDC_OSR_MIN_LOG2 = 4'h7;
  localparam logic [2:0] SDC_SINC3_MAX_CODE = 3'h3;

  // timing in modulator periods; modulator rate is clk_sys / SDC_MOD_DIV
  localparam int SDC_CLK_HZ = 10_000_000;
  localparam int SDC_MOD_DIV = 2;
  localparam int SDC_WAIT_BASE = 256;
  localparam int SDC_WAIT_EXTRA = 44;
  localparam logic [8:0] SDC_WAIT_LAST = 9'(SDC_WAIT_BASE + SDC_WAIT_EXTRA - 1);
  localparam logic [1:0] SDC_FAST_CONV = 2'h2;
  // settling per ratio code 0..7 (432 .. 34864 periods)
  localparam logic [7:0][15:0] SDC_SETTLE_TABLE = {16'h8830, 16'h4830, 16'h2830, 16'h1830,
                                                   16'h0c30, 16'h0630, 16'h0330, 16'h01b0};

  typedef enum logic [1:0] {
    SDC_PATH_WAIT = 2'b00,
    SDC_PATH_FAST = 2'b01,
    SDC_PATH_SINC3 = 2'b10
  } sdc_path_type;
endpackage

/* logic/sdc_chan.sv */
// one channel: sinc3 cic, trailing sinc1 and fast sinc1 path
`timescale 1ns/1ps
module sdc_chan #(
  parameter int CIC_W = sdc_pkg::SDC_CIC_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic restart,
  input wire logic mod_en,
  input wire logic mod_bit,
  input wire logic dec3,
  input wire logic dec_out,
  input wire logic [3:0] k3,
  input wire logic [2:0] m1,
  input wire logic [3:0] kf,
  // results
  output logic [23:0] fast_word,
  output logic [23:0] slow_word
);
  import sdc_pkg::*;

  logic signed [CIC_W-1:0] i1, i2, i3, d1, d2, d3, c1, c2, c3, x;
  logic signed [27:0] acc;
  logic signed [15:0] fsum;
  logic signed [23:0] q3;

  // scale by 2^23 / 2^sh, saturate to 24 bits
  function automatic logic [23:0] norm(input logic signed [63:0] v, input logic [5:0] sh);
    logic signed [63:0] t;
    t = (v <<< SDC_GAIN_FRAC) >>> sh;
    if (t > $signed(64'(SDC_POS_MAX))) norm = SDC_POS_MAX;
    else if (t < -$signed(64'(SDC_NEG_MAX))) norm = SDC_NEG_MAX;
    else norm = t[23:0];
  endfunction

  // one-bit stream mapped to +1 / -1
  assign x = {{(CIC_W-1){~mod_bit}}, 1'b1};

  // wrapping integrators; combs subtract the N-delayed value [R5] [R6]
  always_ff @(posedge clk_sys) begin
    if (!nrst || restart) begin
      i1 <= '0;
      i2 <= '0;
      i3 <= '0;
    end else if (mod_en) begin
      i1 <= i1 + x;
      i2 <= i2 + i1;
      i3 <= i3 + i2;
    end
  end

  always_comb begin
    c1 = i3 - d1;
    c2 = c1 - d2;
    c3 = c2 - d3;
    q3 = norm(64'(c3), 6'(3 * k3)); // divide by N^3 [R5]
  end

  // sinc3 comb delays and sinc1 accumulation of sinc3 outputs [R3] [R4]
  always_ff @(posedge clk_sys) begin
    if (!nrst || restart) begin
      d1 <= '0;
      d2 <= '0;
      d3 <= '0;
      acc <= '0;
      slow_word <= '0;
    end else if (dec3) begin
      d1 <= i3;
      d2 <= c1;
      d3 <= c2;
      if (dec_out) begin
        acc <= '0;
        slow_word <= norm(64'(acc + 28'(q3)), 6'(SDC_GAIN_FRAC + 32'(m1))); // [R4]
      end else begin
        acc <= acc + 28'(q3);
      end
    end
  end

  // fast path: plain average over the whole ratio [R1]
  always_ff @(posedge clk_sys) begin
    if (!nrst || restart) begin
      fsum <= '0;
      fast_word <= '0;
    end else if (dec_out) begin
      fsum <= '0;
      fast_word <= norm(64'(fsum), 6'(kf));
    end else if (mod_en) begin
      fsum <= fsum + 16'(x);
    end
  end
endmodule

/* logic/sdc_top.sv */
// two-channel decimation filter with offset/gain correction and wishbone registers
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module sdc_top #(
  parameter logic [7:0][15:0] SETTLE_MOD = sdc_pkg::SDC_SETTLE_TABLE
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [sdc_pkg::SDC_ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // modulator bitstreams, one per channel
  input wire logic [sdc_pkg::SDC_NCH-1:0] mod_bit,
  // conversion results
  output logic [23:0] conv_data0,
  output logic [23:0] conv_data1,
  output logic conv_strobe,
  output logic conversion_done_n
);
  import sdc_pkg::*;

  logic mod_en;
  logic [SDC_NCH-1:0] mod_sync1, mod_sync2;
  sdc_path_type path;
  logic [8:0] wait_cnt;
  logic [1:0] conv_cnt;
  logic [SDC_CNT_W-1:0] mod_cnt;
  logic dec3_p, dec_out_p, dec_d;
  logic running;
  logic [2:0] osr_code;
  logic [SDC_NCH-1:0] chan_en;
  logic [SDC_IN_CFG_W-1:0] in_cfg [SDC_NCH];
  logic [23:0] offset_coeff [SDC_NCH];
  logic [23:0] gain_coeff [SDC_NCH];
  logic [SDC_NCH-1:0] restart_p;
  logic [SDC_NCH-1:0] chan_clr;
  logic [SDC_SET_W-1:0] settle_cnt [SDC_NCH];
  logic [SDC_NCH-1:0] settled;
  logic [SDC_SET_W-1:0] settle_target;
  logic [23:0] fast_word [SDC_NCH];
  logic [23:0] slow_word [SDC_NCH];
  logic [3:0] k3, kf;
  logic [2:0] m1;
  logic [SDC_CNT_W-1:0] osr_last, mask3;
  logic bus_req, bus_wr;
  logic [31:0] rd_mux, wr_word;
  logic cal_hit;
  logic [0:0] cal_ch;

  // offset first, then gain, then clamp [R11] [R13] [R20]
  function automatic logic [23:0] cal(input logic [23:0] raw, input logic [23:0] off,
                                      input logic [23:0] gain);
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] shifted;
    diff = $signed({raw[23], raw}) - $signed({off[23], off}); // [R11]
    prod = diff * $signed({1'b0, gain}); // [R13]
    shifted = prod >>> SDC_GAIN_FRAC;
    if (shifted > $signed(50'(SDC_POS_MAX))) cal = SDC_POS_MAX; // [R20]
    else if (shifted < -$signed(50'(SDC_NEG_MAX))) cal = SDC_NEG_MAX;
    else cal = shifted[23:0];
  endfunction

  // byte-lane merge of a write onto the current register image
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      wb_merge[8*b +: 8] = sel[b] ? dat[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // ratio decode from the three-bit field [R17]
  always_comb begin
    kf = SDC_OSR_MIN_LOG2 + 4'(osr_code);
    if (osr_code > SDC_SINC3_MAX_CODE) begin
      k3 = SDC_OSR_MIN_LOG2 + 4'(SDC_SINC3_MAX_CODE); // fixed 1024 [R4]
      m1 = osr_code - SDC_SINC3_MAX_CODE; // sinc1 ratio 2..16 [R4]
    end else begin
      k3 = kf; // full ratio in sinc3 [R3]
      m1 = 3'h0;
    end
    osr_last = SDC_CNT_W'((32'h1 << kf) - 1);
    mask3 = SDC_CNT_W'((32'h1 << k3) - 1);
    settle_target = SETTLE_MOD[osr_code]; // [R10]
  end

  // modulator sample enable at half the clock [R18]
  always_ff @(posedge clk_sys) begin
    if (!nrst) mod_en <= 1'b0;
    else mod_en <= ~mod_en;
  end

  // bitstream pins cross in through two flops
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mod_sync1 <= '0;
      mod_sync2 <= '0;
    end else begin
      mod_sync1 <= mod_bit;
      mod_sync2 <= mod_sync1;
    end
  end

  assign running = (path != SDC_PATH_WAIT);

  // start-up wait, fast path for two conversions, then sinc3 for good
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      path <= SDC_PATH_WAIT;
      wait_cnt <= '0;
      conv_cnt <= '0;
    end else begin
      unique case (path)
        SDC_PATH_WAIT: begin
          if (mod_en) begin
            if (wait_cnt == SDC_WAIT_LAST) path <= SDC_PATH_FAST; // [R19]
            else wait_cnt <= wait_cnt + 9'h1;
          end
        end
        SDC_PATH_FAST: begin
          if (dec_d) begin
            conv_cnt <= conv_cnt + 2'h1;
            if (conv_cnt == SDC_FAST_CONV - 2'h1) path <= SDC_PATH_SINC3; // [R2]
          end
        end
        SDC_PATH_SINC3: path <= SDC_PATH_SINC3; // held until reset [R2]
        default: path <= SDC_PATH_WAIT;
      endcase
    end
  end

  // shared decimation phase; a resync restarts it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mod_cnt <= '0;
      dec3_p <= 1'b0;
      dec_out_p <= 1'b0;
      dec_d <= 1'b0;
    end else begin
      // a one-channel restart must not cost the other channel a decimation
      dec3_p <= mod_en && running && ((mod_cnt & mask3) == mask3) && !(&restart_p);
      dec_out_p <= mod_en && running && (mod_cnt == osr_last) && !(&restart_p);
      dec_d <= dec_out_p;
      if (&restart_p) mod_cnt <= '0; // [R7]
      else if (mod_en && running) mod_cnt <= (mod_cnt == osr_last) ? '0 : mod_cnt + 1'b1;
    end
  end

  assign chan_clr = restart_p | ~chan_en;

  // settling counters; restart clears them [R7] [R10]
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int c = 0; c < SDC_NCH; c++) settle_cnt[c] <= '0;
    end else begin
      for (int c = 0; c < SDC_NCH; c++) begin
        if (chan_clr[c]) settle_cnt[c] <= '0;
        else if (mod_en && running && settle_cnt[c] < settle_target) settle_cnt[c] <= settle_cnt[c] + 1'b1;
      end
    end
  end

  always_comb begin
    for (int c = 0; c < SDC_NCH; c++) settled[c] = (settle_cnt[c] >= settle_target);
  end

  // filter chains; disabled or restarted channels hold cleared state [R7]
  for (genvar g = 0; g < SDC_NCH; g++) begin : g_chan
    sdc_chan #(.CIC_W(SDC_CIC_W)) u_chan (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .restart(chan_clr[g]),
      .mod_en(mod_en && running),
      .mod_bit(mod_sync2[g]),
      .dec3(dec3_p),
      .dec_out(dec_out_p),
      .k3(k3),
      .m1(m1),
      .kf(kf),
      .fast_word(fast_word[g]),
      .slow_word(slow_word[g])
    );
  end

  // both words and one strobe per output period; no gating while settling [R8] [R21]
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      conv_data0 <= '0;
      conv_data1 <= '0;
      conv_strobe <= 1'b0;
      conversion_done_n <= 1'b1;
    end else begin
      conv_strobe <= dec_d; // [R21]
      conversion_done_n <= ~dec_d;
      if (dec_d) begin
        // fast words only while the path is still in its first two conversions [R1]
        conv_data0 <= cal(path == SDC_PATH_FAST ? fast_word[0] : slow_word[0],
                          offset_coeff[0], gain_coeff[0]); // [R15]
        conv_data1 <= cal(path == SDC_PATH_FAST ? fast_word[1] : slow_word[1],
                          offset_coeff[1], gain_coeff[1]); // [R15]
      end
    end
  end

  // wishbone: ack one cycle after the request, write lands on the ack edge
  assign bus_req = wb_cyc && wb_stb;
  assign bus_wr = bus_req && wb_we && wb_ack;
  assign cal_hit = (wb_adr[7:5] == SDC_CAL_PAGE0[3:1]);
  assign cal_ch = wb_adr[4];

  always_comb begin
    rd_mux = 32'h0;
    if (cal_hit) begin
      unique case (wb_adr[3:2])
        SDC_CAL_OFF_HI: rd_mux = 32'(offset_coeff[cal_ch][23:SDC_COEF_HI_LSB]);
        SDC_CAL_OFF_LO: rd_mux = 32'(offset_coeff[cal_ch][SDC_COEF_HI_LSB-1:0]);
        SDC_CAL_GAIN_HI: rd_mux = 32'(gain_coeff[cal_ch][23:SDC_COEF_HI_LSB]);
        SDC_CAL_GAIN_LO: rd_mux = 32'(gain_coeff[cal_ch][SDC_COEF_HI_LSB-1:0]);
      endcase
    end else begin
      case (wb_adr)
        SDC_REG_CLK_CFG: rd_mux = 32'(osr_code);
        SDC_REG_CHAN_CTRL: rd_mux = 32'(chan_en);
        SDC_REG_IN_CFG0: rd_mux = 32'(in_cfg[0]);
        SDC_REG_IN_CFG1: rd_mux = 32'(in_cfg[1]);
        SDC_REG_STATUS: begin
          rd_mux[SDC_NCH-1:0] = settled;
          rd_mux[SDC_ST_FAST_BIT] = (path == SDC_PATH_FAST);
          rd_mux[SDC_ST_RUN_BIT] = running;
        end
        SDC_REG_DATA0: rd_mux = {{8{conv_data0[23]}}, conv_data0};
        SDC_REG_DATA1: rd_mux = {{8{conv_data1[23]}}, conv_data1};
        default: rd_mux = 32'h0;
      endcase
    end
    wr_word = wb_merge(rd_mux, wb_dat_w, wb_sel);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wb_ack <= 1'b0;
      wb_dat_r <= '0;
    end else begin
      wb_ack <= bus_req && !wb_ack;
      if (bus_req && !wb_ack) wb_dat_r <= rd_mux;
    end
  end

  // configuration registers and the restart events they cause
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      osr_code <= SDC_OSR_RST;
      chan_en <= SDC_EN_RST;
      restart_p <= '0;
      for (int c = 0; c < SDC_NCH; c++) in_cfg[c] <= SDC_IN_CFG_RST;
    end else begin
      restart_p <= '0;
      if (bus_wr && !cal_hit) begin
        case (wb_adr)
          SDC_REG_CLK_CFG: begin
            osr_code <= wr_word[2:0]; // [R17]
            if (wr_word[2:0] != osr_code) restart_p <= '1;
          end
          SDC_REG_CHAN_CTRL: begin
            chan_en <= wr_word[SDC_NCH-1:0];
            // newly enabled channels and resync restart settling [R7]
            restart_p <= (wr_word[SDC_NCH-1:0] & ~chan_en) | {SDC_NCH{wr_word[SDC_RESYNC_BIT]}};
          end
          SDC_REG_IN_CFG0: begin
            in_cfg[0] <= wr_word[SDC_IN_CFG_W-1:0];
            restart_p[0] <= (wr_word[SDC_IN_CFG_W-1:0] != in_cfg[0]); // [R7]
          end
          SDC_REG_IN_CFG1: begin
            in_cfg[1] <= wr_word[SDC_IN_CFG_W-1:0];
            restart_p[1] <= (wr_word[SDC_IN_CFG_W-1:0] != in_cfg[1]); // [R7]
          end
          default: restart_p <= '0;
        endcase
      end
    end
  end

  // per-channel coefficients, high and low parts, volatile [R12] [R14] [R15]
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int c = 0; c < SDC_NCH; c++) begin
        offset_coeff[c] <= SDC_OFFSET_RST;
        gain_coeff[c] <= SDC_GAIN_RST;
      end
    end else if (bus_wr && cal_hit) begin
      unique case (wb_adr[3:2])
        SDC_CAL_OFF_HI: offset_coeff[cal_ch][23:SDC_COEF_HI_LSB] <= wr_word[15:0]; // [R12]
        SDC_CAL_OFF_LO: offset_coeff[cal_ch][SDC_COEF_HI_LSB-1:0] <= wr_word[7:0]; // [R12]
        SDC_CAL_GAIN_HI: gain_coeff[cal_ch][23:SDC_COEF_HI_LSB] <= wr_word[15:0]; // [R14]
        SDC_CAL_GAIN_LO: gain_coeff[cal_ch][SDC_COEF_HI_LSB-1:0] <= wr_word[7:0]; // [R14]
      endcase
    end
  end
endmodule

/* sim/sdc_top_sva.sv */
// port assertions for the decimator top
`timescale 1ns/1ps
module sdc_top_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register bus
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_ack,
  // results
  input wire logic [23:0] conv_data0,
  input wire logic [23:0] conv_data1,
  input wire logic conv_strobe,
  input wire logic conversion_done_n
);
  logic [15:0] since_rst;
  logic [15:0] since_strobe;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // saturating, so a long run cannot fake an early strobe
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      since_rst <= 16'h0;
    end else if (since_rst != 16'hffff) begin
      since_rst <= since_rst + 16'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst || conv_strobe) begin
      since_strobe <= 16'h0;
    end else if (since_strobe != 16'hffff) begin
      since_strobe <= since_strobe + 16'h1;
    end
  end
  sequence bus_req;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence ack_once;
    wb_ack ##1 !wb_ack;
  endsequence
  bus_answer_a: assert property (bus_req |=> ack_once)
    else $error("bus request not answered in one cycle");
  ack_cause_a: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
    else $error("ack without a request");
  done_inverse_a: assert property (conversion_done_n != conv_strobe)
    else $error("done flag not inverse of strobe");
  strobe_pulse_a: assert property (conv_strobe |=> !conv_strobe)
    else $error("strobe longer than one cycle");
  data_hold_a: assert property (!conv_strobe |-> $stable(conv_data0) && $stable(conv_data1))
    else $error("result changed without strobe");
  start_wait_a: assert property (conv_strobe |-> since_rst > 16'd600)
    else $error("result before start-up wait");
  strobe_gap_a: assert property (conv_strobe |-> since_strobe >= 16'd255)
    else $error("strobes closer than shortest period");
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> !conv_strobe && !wb_ack && conv_data0 == 24'h0)
    else $error("outputs active after reset");
endmodule

/* sim/sdc_mod_model.sv */
// modulator bitstream source: steady ones or alternating bits
`timescale 1ns/1ps
module sdc_mod_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // per channel: 1 all ones, 0 alternating
  input wire logic [1:0] ones,
  // bitstreams
  output logic [1:0] mod_bit
);
  logic half;
  logic alt;
  // one new bit every second clock
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      half <= 1'b0;
      alt <= 1'b0;
    end else begin
      half <= !half;
      alt <= half ? !alt : alt;
    end
  end
  // alternating bits average to exactly zero over any even window
  assign mod_bit = ones | {2{alt}};
endmodule

/* sim/sdc_top_test.sv */
// self-checking bench for the decimator with calibration
`timescale 1ns/1ps
module sdc_top_test;
  import sdc_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [SDC_ADR_W-1:0] wb_adr = '0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic [SDC_NCH-1:0] mod_bit;
  logic [1:0] ones = 2'h1;
  logic [23:0] conv_data0;
  logic [23:0] conv_data1;
  logic conv_strobe;
  logic conversion_done_n;
  logic [31:0] rd;
  logic [31:0] lfsr = 32'h5394395b;
  logic [47:0] e_now;
  logic [47:0] exp_q[$];
  int errors = 0;
  int check_count = 0;
  int n_strobe = 0;
  int cyc_now = 0;
  int last_at = 0;
  int last_gap = 0;
  sdc_top i_sdc_top (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .mod_bit(mod_bit), .conv_data0(conv_data0), .conv_data1(conv_data1), .conv_strobe(conv_strobe),
    .conversion_done_n(conversion_done_n));
  sdc_mod_model i_sdc_mod_model (.clk_sys(clk_sys), .nrst(nrst), .ones(ones), .mod_bit(mod_bit));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat_w <= dat;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_dat_r;
    chk("wb_ack", 32'h1, {31'h0, wb_ack});
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  // next random word from the bench lfsr
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // correction rounds toward minus infinity, so the shift here floors as well
  function automatic logic [23:0] cal_exp(input logic [23:0] x, input logic [23:0] off, input logic [23:0] g);
    longint d;
    d = longint'($signed(x)) - longint'($signed(off));
    d = (d * longint'(g)) >>> 23;
    if (d > 64'sd8388607) return 24'h7fffff;
    if (d < -64'sd8388608) return 24'h800000;
    return d[23:0];
  endfunction
  task automatic wait_strobe(input int k);
    int t;
    t = n_strobe + k;
    wait (n_strobe >= t);
  endtask
  task automatic want(input int skip, input logic [23:0] e0, input logic [23:0] e1);
    wait_strobe(skip);
    exp_q.push_back({e0, e1});
    wait_strobe(1);
  endtask
  task automatic cal(input int ch, input logic [23:0] off, input logic [23:0] g);
    logic [7:0] base;
    base = 8'h20 + 8'(ch * 16);
    bus(1'b1, base, {16'h0, off[23:8]});
    bus(1'b1, base + 8'h4, {24'h0, off[7:0]});
    bus(1'b1, base + 8'h8, {16'h0, g[23:8]});
    bus(1'b1, base + 8'hc, {24'h0, g[7:0]});
  endtask
  task automatic calchk(input logic [23:0] o0, input logic [23:0] g0, input logic [23:0] o1, input logic [23:0] g1);
    cal(0, o0, g0);
    cal(1, o1, g1);
    want(1, cal_exp(24'h7fffff, o0, g0), cal_exp(24'h0, o1, g1));
  endtask
  // results are compared half a cycle after the strobe edge
  always @(negedge clk_sys) begin
    cyc_now++;
    if (conv_strobe === 1'b1) begin
      last_gap = cyc_now - last_at;
      last_at = cyc_now;
      if (exp_q.size() > 0) begin
        e_now = exp_q.pop_front();
        chk("conv_data0", {8'h0, e_now[47:24]}, {8'h0, conv_data0});
        chk("conv_data1", {8'h0, e_now[23:0]}, {8'h0, conv_data1});
      end
      n_strobe++;
    end
  end
  initial begin
    repeat (80000) @(posedge clk_sys);
    errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    bus(1'b0, 8'h28, 32'h0);
    chk("gain_hi", 32'h8000, rd);
    bus(1'b0, 8'h3c, 32'h0);
    chk("gain_lo", 32'h0, rd);
    bus(1'b0, 8'h30, 32'h0);
    chk("offset_hi", 32'h0, rd);
    bus(1'b0, 8'h44, 32'h0);
    chk("unmapped", 32'h0, rd);
    want(0, 24'h7fffff, 24'h0);
    bus(1'b0, SDC_REG_STATUS, 32'h0);
    chk("fast_flag", 32'h1, {31'h0, rd[SDC_ST_FAST_BIT]});
    want(0, 24'h7fffff, 24'h0);
    wait_strobe(1);
    bus(1'b0, SDC_REG_STATUS, 32'h0);
    chk("fast_flag", 32'h0, {31'h0, rd[SDC_ST_FAST_BIT]});
    want(1, 24'h7fffff, 24'h0);
    for (int c = 5; c >= 0; c--) begin
      bus(1'b1, SDC_REG_CLK_CFG, 32'(c));
      wait_strobe(2);
      chk("period", 32'(2 << (7 + c)), 32'(last_gap));
      if (c == 4) want(1, 24'h7fffff, 24'h0);
    end
    repeat (400) @(posedge clk_sys);
    bus(1'b0, SDC_REG_STATUS, 32'h0);
    chk("settled", 32'h3, {30'h0, rd[1:0]});
    bus(1'b1, SDC_REG_IN_CFG1, 32'h1);
    bus(1'b0, SDC_REG_STATUS, 32'h0);
    chk("settled", 32'h1, {30'h0, rd[1:0]});
    repeat (790) @(posedge clk_sys);
    bus(1'b0, SDC_REG_STATUS, 32'h0);
    chk("settled", 32'h1, {30'h0, rd[1:0]});
    repeat (100) @(posedge clk_sys);
    bus(1'b0, SDC_REG_STATUS, 32'h0);
    chk("settled", 32'h3, {30'h0, rd[1:0]});
    bus(1'b1, SDC_REG_CHAN_CTRL, 32'h103);
    bus(1'b0, SDC_REG_STATUS, 32'h0);
    chk("settled", 32'h0, {30'h0, rd[1:0]});
    wait_strobe(4);
    calchk(24'h000001, SDC_GAIN_RST, 24'hffff00, 24'h400000);
    calchk(24'h000000, 24'h000001, 24'h800000, SDC_GAIN_RST);
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      calchk(lfsr[23:0], {lfsr[7:0], lfsr[31:16]}, lfsr[31:8], SDC_GAIN_RST);
    end
    stop_test();
  end
endmodule
bind sdc_top sdc_top_sva i_sdc_top_sva (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_ack(wb_ack), .conv_data0(conv_data0), .conv_data1(conv_data1), .conv_strobe(conv_strobe),
  .conversion_done_n(conversion_done_n));
